// [core/xbc_bus_ctrl.sv]
// Bus cycle sequencer and reset handling for external program, data and port space
`timescale 1ns/1ps
`default_nettype none
module xbc_bus_ctrl
   import xbc_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        reset,
   input  wire logic        clkEn,
   input  wire logic        reset_in_n,
   input  wire xbc_req_type opReq,
   input  wire logic [15:0] dataIn,
   output xbc_bus_type      busOut,
   output logic [11:0]      programCounter,
   output logic [15:0]      fetchWord,
   output logic             fetchValid,
   output logic [15:0]      readWord,
   output logic             readValid,
   output logic             opAccept,
   output logic             inReset
);
   // Each bus cycle is split in two phases so write data leads the strobe
   typedef enum logic [3:0] {
      XBC_ST_RESET,
      XBC_ST_WAKE,
      XBC_ST_FETCH,
      XBC_ST_DUMMY,
      XBC_ST_TRD_DATA,
      XBC_ST_TWR_SETUP,
      XBC_ST_TWR_STROBE,
      XBC_ST_PIN_DATA,
      XBC_ST_POUT_SETUP,
      XBC_ST_POUT_STROBE
   } xbc_state_type;

   xbc_state_type state_q, state_d;
   xbc_req_type   req_q;
   logic          rstSync;
   logic          rstSync_q;
   logic          rstHeld_q;
   logic          phase_q;
   logic [11:0]   pc_q;
   logic [11:0]   addr_q;
   logic [15:0]   dOut_q;
   logic          dOe_n_q;
   logic          rd_n_q;
   logic          wr_n_q;
   logic          strOe_n_q;
   logic          aOe_n_q;
   logic [15:0]   fetch_q;
   logic          fetchV_q;
   logic [15:0]   read_q;
   logic          readV_q;

   // Pin is asynchronous, two flops before use
   xbc_sync uSync (
      .ref_clk (ref_clk),
      .reset   (reset),
      .clkEn   (clkEn),
      .asyncIn (reset_in_n),
      .syncOut (rstSync)
   );

   wire rstActive = ~rstSync;
   wire cycleEnd  = phase_q;
   wire isWrite   = (state_q == XBC_ST_TWR_STROBE) || (state_q == XBC_ST_POUT_STROBE);
   wire isReadCyc = (state_q == XBC_ST_FETCH) || (state_q == XBC_ST_DUMMY)
                  || (state_q == XBC_ST_TRD_DATA) || (state_q == XBC_ST_PIN_DATA);
   wire takeOp    = (state_q == XBC_ST_FETCH) && cycleEnd && !rstActive;
   wire [11:0] busAddr = (state_q == XBC_ST_FETCH || state_q == XBC_ST_DUMMY)
                       ? pc_q : req_q.operandAddr;

   // Sequencer: RESET and WAKE take one clock each once released; every other state lasts one two-phase bus cycle
   always_comb
   begin
      state_d = state_q;
      if (rstActive)
         state_d = XBC_ST_RESET;
      else if (state_q == XBC_ST_RESET)
         state_d = XBC_ST_WAKE;
      else if (state_q == XBC_ST_WAKE)
         state_d = XBC_ST_FETCH;
      else if (cycleEnd)
      begin
         unique case (state_q)
            XBC_ST_FETCH:
            begin
               unique case (opReq.op)
                  XBC_OP_TABLE_READ:  state_d = XBC_ST_DUMMY;
                  XBC_OP_TABLE_WRITE: state_d = XBC_ST_DUMMY;
                  XBC_OP_PORT_IN:     state_d = XBC_ST_PIN_DATA;
                  XBC_OP_PORT_OUT:    state_d = XBC_ST_POUT_SETUP;
                  default:            state_d = XBC_ST_FETCH;
               endcase
            end
            XBC_ST_DUMMY:
               state_d = (req_q.op == XBC_OP_TABLE_READ) ? XBC_ST_TRD_DATA
                                                         : XBC_ST_TWR_SETUP;
            XBC_ST_TWR_SETUP:   state_d = XBC_ST_TWR_STROBE;
            XBC_ST_POUT_SETUP:  state_d = XBC_ST_POUT_STROBE;
            default:            state_d = XBC_ST_FETCH;
         endcase
      end
   end

   // State, phase and captured request
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         state_q <= XBC_ST_RESET;
         phase_q <= 1'b0;
         req_q   <= '0;
      end
      else if (clkEn)
      begin
         state_q <= state_d;
         phase_q <= (state_d != state_q || rstActive) ? 1'b0 : ~phase_q;
         if (takeOp)
            req_q <= opReq;
      end
   end

   // Reset entry: strobes high now, float and clear two cycles later
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         rstSync_q <= 1'b1;
         rstHeld_q <= 1'b1;
      end
      else if (clkEn)
      begin
         rstSync_q <= rstSync;
         rstHeld_q <= rstActive && !rstSync_q;
      end
   end

   // Program counter advances at the end of each instruction fetch
   always_ff @(posedge ref_clk)
   begin
      if (reset)
         pc_q <= PC_RESET;
      else if (clkEn)
      begin
         if (rstHeld_q)
            pc_q <= PC_RESET;
         else if (state_q == XBC_ST_FETCH && cycleEnd && !rstActive)
            pc_q <= pc_q + 12'h001;
      end
   end

   // Pin drivers; strobes only low in the second phase of a cycle
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         addr_q    <= ADDR_RESET;
         aOe_n_q   <= 1'b1;
         dOut_q    <= DATA_RESET;
         dOe_n_q   <= 1'b1;
         rd_n_q    <= 1'b1;
         wr_n_q    <= 1'b1;
         strOe_n_q <= 1'b1;
      end
      else if (clkEn)
      begin
         if (rstActive)
         begin
            rd_n_q  <= 1'b1;
            wr_n_q  <= 1'b1;
            dOe_n_q <= 1'b1;
            if (rstHeld_q)
            begin
               strOe_n_q <= 1'b1;
               aOe_n_q   <= 1'b1;
               addr_q    <= ADDR_RESET;
            end
         end
         else if (state_q == XBC_ST_RESET || state_q == XBC_ST_WAKE)
         begin
            strOe_n_q <= 1'b0;
            aOe_n_q   <= 1'b0;
            addr_q    <= ADDR_RESET;
         end
         else
         begin
            addr_q  <= busAddr;
            // Data driven in setup and strobe phases, ahead of the write edge
            dOe_n_q <= !(state_d == XBC_ST_TWR_SETUP || state_d == XBC_ST_TWR_STROBE
                       || state_d == XBC_ST_POUT_SETUP || state_d == XBC_ST_POUT_STROBE);
            dOut_q  <= takeOp ? opReq.writeData : req_q.writeData;
            rd_n_q  <= !(isReadCyc && !phase_q);
            wr_n_q  <= !(isWrite && !phase_q);
         end
      end
   end

   // Capture read data at the end of the strobe
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         fetch_q  <= DATA_RESET;
         fetchV_q <= 1'b0;
         read_q   <= DATA_RESET;
         readV_q  <= 1'b0;
      end
      else if (clkEn)
      begin
         fetchV_q <= (state_q == XBC_ST_FETCH) && cycleEnd && !rstActive;
         readV_q  <= (state_q == XBC_ST_TRD_DATA || state_q == XBC_ST_PIN_DATA) && cycleEnd;
         if (state_q == XBC_ST_FETCH && cycleEnd)
            fetch_q <= dataIn;
         if ((state_q == XBC_ST_TRD_DATA || state_q == XBC_ST_PIN_DATA) && cycleEnd)
            read_q <= dataIn;
      end
   end

   assign busOut.addr          = addr_q;
   assign busOut.addrOe_n      = aOe_n_q;
   assign busOut.dataOut       = dOut_q;
   assign busOut.dataOe_n      = dOe_n_q;
   assign busOut.readStrobe_n  = rd_n_q;
   assign busOut.writeStrobe_n = wr_n_q;
   assign busOut.strobeOe_n    = strOe_n_q;
   assign programCounter       = pc_q;
   assign fetchWord            = fetch_q;
   assign fetchValid           = fetchV_q;
   assign readWord             = read_q;
   assign readValid            = readV_q;
   assign opAccept             = takeOp;
   assign inReset              = (state_q == XBC_ST_RESET);
   // Checks
   property p_strobe_excl;
      @(posedge ref_clk) disable iff (reset)
      !(!busOut.readStrobe_n && !busOut.writeStrobe_n);
   endproperty
   a_strobe_excl: assert property (p_strobe_excl) else $error("both strobes low");
   property p_reset_strobes_high;
      @(posedge ref_clk) disable iff (reset)
      (clkEn && rstActive) |=> (busOut.readStrobe_n && busOut.writeStrobe_n);
   endproperty
   a_reset_strobes_high: assert property (p_reset_strobes_high) else $error("strobe low in reset");
   // Three reset cycles in a row, so the two-cycle float delay on entry cannot trip it
   property p_reset_float;
      @(posedge ref_clk) disable iff (reset)
      (clkEn && rstActive)[*3] |=> (busOut.addrOe_n && busOut.strobeOe_n);
   endproperty
   a_reset_float: assert property (p_reset_float) else $error("bus not floated");
   property p_pc_clear;
      @(posedge ref_clk) disable iff (reset)
      (clkEn && rstHeld_q) |=> (pc_q == PC_RESET && addr_q == ADDR_RESET);
   endproperty
   a_pc_clear: assert property (p_pc_clear) else $error("pc not cleared");
   property p_resume;
      @(posedge ref_clk) disable iff (reset || !clkEn)
      (state_q == XBC_ST_RESET && !rstActive) |=> state_q == XBC_ST_WAKE ##1 state_q == XBC_ST_FETCH;
   endproperty
   a_resume: assert property (p_resume) else $error("resume late");
   property p_write_data_lead;
      @(posedge ref_clk) disable iff (reset)
      $fell(busOut.writeStrobe_n) |-> !$past(busOut.dataOe_n);
   endproperty
   a_write_data_lead: assert property (p_write_data_lead) else $error("data late");
   property p_write_only_out;
      @(posedge ref_clk) disable iff (reset)
      !busOut.writeStrobe_n |-> !busOut.dataOe_n;
   endproperty
   a_write_only_out: assert property (p_write_only_out) else $error("write without data");
   property p_trd_order;
      @(posedge ref_clk) disable iff (reset || !clkEn || rstActive)
      (state_q == XBC_ST_DUMMY && req_q.op == XBC_OP_TABLE_READ && cycleEnd)
      |=> state_q == XBC_ST_TRD_DATA ##2 state_q == XBC_ST_FETCH;
   endproperty
   a_trd_order: assert property (p_trd_order) else $error("table read order");
   property p_pin_addr;
      @(posedge ref_clk) disable iff (reset || !clkEn || rstActive)
      (state_q == XBC_ST_PIN_DATA) |=> busOut.addr == $past(req_q.operandAddr);
   endproperty
   a_pin_addr: assert property (p_pin_addr) else $error("port address wrong");
   c_trd:  cover property (@(posedge ref_clk) state_q == XBC_ST_TRD_DATA);
   c_twr:  cover property (@(posedge ref_clk) state_q == XBC_ST_TWR_STROBE);
   c_pout: cover property (@(posedge ref_clk) state_q == XBC_ST_POUT_STROBE);
   c_rst:  cover property (@(posedge ref_clk) $fell(rstActive));
endmodule
`default_nettype wire

// [core/xbc_pkg.sv]
// Package of constants and types for the external bus cycle and reset controller
package xbc_pkg;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 16;
   localparam logic [11:0] ADDR_RESET = 12'h000;
   localparam logic [11:0] PC_RESET = 12'h000;
   localparam logic [15:0] DATA_RESET = 16'h0000;
   // Least reset pulse from the outside party, in processor cycles
   localparam int RESET_MIN_CYCLES = 5;

   // Operation codes requested by the core
   typedef enum logic [2:0] {
      XBC_OP_NONE,
      XBC_OP_TABLE_READ,
      XBC_OP_TABLE_WRITE,
      XBC_OP_PORT_IN,
      XBC_OP_PORT_OUT
   } xbc_op_type;

   // Operation request from the core
   typedef struct packed {
      xbc_op_type        op;
      logic [11:0]       operandAddr;
      logic [15:0]       writeData;
   } xbc_req_type;

   // External bus pins, enables active low
   typedef struct packed {
      logic [11:0]       addr;
      logic              addrOe_n;
      logic [15:0]       dataOut;
      logic              dataOe_n;
      logic              readStrobe_n;
      logic              writeStrobe_n;
      logic              strobeOe_n;
   } xbc_bus_type;
endpackage

// [core/xbc_sync.sv]
// Two-stage synchroniser for an asynchronous level
`timescale 1ns/1ps
`default_nettype none
module xbc_sync
   import xbc_pkg::*;
(
   input  wire logic ref_clk,
   input  wire logic reset,
   input  wire logic clkEn,
   input  wire logic asyncIn,
   output logic      syncOut
);
   logic stage1_q;
   logic stage2_q;

   // Resets high so a released pin reads idle
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         stage1_q <= 1'b1;
         stage2_q <= 1'b1;
      end
      else if (clkEn)
      begin
         stage1_q <= asyncIn;
         stage2_q <= stage1_q;
      end
   end

   assign syncOut = stage2_q;
endmodule
`default_nettype wire

// [sim/xbc_mem_model.sv]
// Behavioural external memory and port space facing the bus controller
`timescale 1ns/1ps
`default_nettype none
module xbc_mem_model
   import xbc_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire xbc_bus_type busOut,
   output logic [15:0]      dataIn,
   output logic [11:0]      wrAddr,
   output logic [15:0]      wrData
);
   logic [15:0] lastQ = 16'h0000;
   logic        answering;

   // Answer only while an address is driven and the controller leaves the data bus
   assign answering = !busOut.addrOe_n && busOut.dataOe_n;
   // Released bus shows the inverse of the last answer, never a stale copy
   assign dataIn    = answering ? {4'hA, busOut.addr} : ~lastQ;

   // Remember the last answer and capture each strobed write
   always_ff @(posedge ref_clk)
   begin
      if (answering)
         lastQ <= dataIn;
      if (!busOut.strobeOe_n && !busOut.writeStrobe_n)
      begin
         wrAddr <= busOut.addr;
         wrData <= busOut.dataOut;
      end
   end
endmodule
`default_nettype wire

// [sim/tb.sv]
// Self-checking bench for the external bus cycle and reset controller
`timescale 1ns/1ps
`default_nettype none
module tb
   import xbc_pkg::*;
();
   logic        ref_clk, reset, clkEn, reset_in_n;
   xbc_req_type opReq;
   xbc_bus_type busOut, busPrev, busHeld;
   logic [15:0] dataIn, fetchWord, readWord, wrData;
   logic [11:0] programCounter, wrAddr;
   logic        fetchValid, readValid, opAccept, inReset;
   int          n_fail = 0;
   int          n_compared = 0;
   int          cycles = 0;
   int          rdFalls = 0;
   int          wrFalls = 0;

   xbc_bus_ctrl dut (.ref_clk(ref_clk), .reset(reset), .clkEn(clkEn),
      .reset_in_n(reset_in_n), .opReq(opReq), .dataIn(dataIn), .busOut(busOut),
      .programCounter(programCounter), .fetchWord(fetchWord), .fetchValid(fetchValid),
      .readWord(readWord), .readValid(readValid), .opAccept(opAccept), .inReset(inReset));
   xbc_mem_model mem (.ref_clk(ref_clk), .busOut(busOut), .dataIn(dataIn),
      .wrAddr(wrAddr), .wrData(wrData));

   // 40 MHz clock
   initial
   begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end

   task automatic chk(input string name, input logic [47:0] exp, input logic [47:0] got);
      n_compared++;
      if (got !== exp)
      begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic tally_and_finish;
      $display("Compared %0d mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // Hang guard, generous against the hundred or so cycles needed
   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         n_fail++;
         tally_and_finish();
      end
   end

   // Settled-bus watch: overlap, write setup, release order, strobe counts
   always @(negedge ref_clk)
   begin
      if (!reset && !busOut.strobeOe_n)
         chk("one strobe", 1, busOut.readStrobe_n | busOut.writeStrobe_n);
      if (!reset && busPrev.writeStrobe_n && !busOut.writeStrobe_n)
         chk("data before write", {1'b0, busOut.dataOut},
             {busPrev.dataOe_n, busPrev.dataOut});
      if (!reset && !busPrev.strobeOe_n && busOut.strobeOe_n)
         chk("strobes before float", 2'b11,
             {busPrev.readStrobe_n, busPrev.writeStrobe_n});
      if (busPrev.readStrobe_n && !busOut.readStrobe_n)
         rdFalls++;
      if (busPrev.writeStrobe_n && !busOut.writeStrobe_n)
         wrFalls++;
      busPrev = busOut;
   end

   // Request stays applied after acceptance until the next call replaces it
   task automatic do_op(input xbc_op_type op, input logic [11:0] a, input logic [15:0] d);
      int i;
      i = 0;
      opReq <= '{op, a, d};
      do
      begin
         @(negedge ref_clk);
         i++;
      end while (opAccept !== 1'b1 && i < 40);
      chk("op taken", 1, opAccept);
      @(posedge ref_clk);
   endtask

   // One operation, then strobe counts up to the next instruction's acceptance
   task automatic op_case(input xbc_op_type op, input logic [11:0] a, input logic [15:0] d,
                          input int nRd, input int nWr);
      int r0, w0, i;
      do_op(op, a, d);
      r0 = rdFalls;
      w0 = wrFalls;
      if (op == XBC_OP_TABLE_READ || op == XBC_OP_PORT_IN)
      begin
         i = 0;
         do
         begin
            @(negedge ref_clk);
            i++;
         end while (readValid !== 1'b1 && i < 20);
         chk("read word", {4'hA, a}, readWord);
         @(posedge ref_clk);
      end
      do_op(XBC_OP_NONE, 12'h000, 16'h0000);
      chk("read strobes", nRd, rdFalls - r0);
      chk("write strobes", nWr, wrFalls - w0);
   endtask

   task automatic test_reads;
      op_case(XBC_OP_TABLE_READ, 12'h3A5, 16'h0000, 3, 0);
      op_case(XBC_OP_PORT_IN, 12'h006, 16'h0000, 2, 0);
   endtask

   task automatic test_writes;
      op_case(XBC_OP_TABLE_WRITE, 12'h0C3, 16'hBEEF, 2, 1);
      chk("table write", {12'h0C3, 16'hBEEF}, {wrAddr, wrData});
      op_case(XBC_OP_PORT_OUT, 12'h007, 16'h5A5A, 1, 1);
      chk("port write", {12'h007, 16'h5A5A}, {wrAddr, wrData});
   endtask

   // Reset pin pulled in mid-operation, then released
   task automatic test_reset;
      int i;
      do_op(XBC_OP_TABLE_READ, 12'h111, 16'h0000);
      reset_in_n <= 1'b0;
      opReq <= '{XBC_OP_NONE, 12'h000, 16'h0000};
      repeat (RESET_MIN_CYCLES) @(posedge ref_clk);
      @(negedge ref_clk);
      chk("floated", 3'b111, {busOut.addrOe_n, busOut.dataOe_n, busOut.strobeOe_n});
      chk("addr and pc", 0, {busOut.addr, programCounter});
      chk("in reset", 1, inReset);
      @(posedge ref_clk);
      reset_in_n <= 1'b1;
      i = 0;
      do
      begin
         @(negedge ref_clk);
         i++;
      end while (busOut.addrOe_n !== 1'b0 && i < 8);
      chk("first address", 0, {busOut.addrOe_n, busOut.addr});
      i = 0;
      while (fetchValid !== 1'b1 && i < 8)
      begin
         @(negedge ref_clk);
         i++;
      end
      chk("first fetch", {4'hA, 12'h000}, fetchWord);
   endtask

   // Clock enable low freezes the pins
   task automatic test_freeze;
      @(posedge ref_clk);
      clkEn <= 1'b0;
      @(negedge ref_clk);
      busHeld = busOut;
      repeat (3) @(negedge ref_clk);
      chk("frozen bus", busHeld, busOut);
      @(posedge ref_clk);
      clkEn <= 1'b1;
   endtask

   initial
   begin
      reset = 1'b1;
      clkEn = 1'b1;
      reset_in_n = 1'b1;
      opReq = '{XBC_OP_NONE, 12'h000, 16'h0000};
      repeat (6) @(posedge ref_clk);
      reset <= 1'b0;
      test_reads();
      test_writes();
      test_reset();
      test_freeze();
      test_reads();
      tally_and_finish();
   end
endmodule
`default_nettype wire
